// ---- dv/cps_afe_model.sv ----
// Analog partner: supply, converter soft start and input current level.
// Assumes the bench says when the load stops drawing current.
`timescale 1ns/1ps
`default_nettype none
module cps_afe_model (
  // Clock, reset and charger state
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic chargeEnable,
  input  wire logic noLoad,          // Input current collapses
  // Levels toward the supervisor
  output logic      supplyOk,
  output logic      softStartActive,
  output logic      switching,
  output logic      ucpAboveRise,
  output logic      ucpBelowFall
);
  logic [3:0] ssCnt_q;               // Cycles since charge enable rose
  // Soft start lasts eight cycles; kept short so runs stay brief
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ssCnt_q <= 4'h0;
      supplyOk <= 1'b0;
    end else begin
      supplyOk <= 1'b1;
      if (!chargeEnable) ssCnt_q <= 4'h0;
      else if (ssCnt_q != 4'hf) ssCnt_q <= ssCnt_q + 4'h1;
    end
  end
  // Switching starts halfway through soft start
  assign softStartActive = chargeEnable && ssCnt_q < 4'h8;
  assign switching = chargeEnable && ssCnt_q >= 4'h4;
  // Current follows the converter; no load means no current
  assign ucpAboveRise = switching && !noLoad;
  assign ucpBelowFall = switching && noLoad;
endmodule
`default_nettype wire

// ---- dv/cps_sup_properties.sv ----
// Port-level properties of the protection supervisor.
// Assumes one clock domain and the word-addressed register slave.
`timescale 1ns/1ps
`default_nettype none
`include "cps_regs.vh"
module cps_sup_checker #(
  parameter PRES_CYC = 20000        // Presence qualification cycles
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  // Comparators
  input wire logic        adapterPresent,
  input wire logic        adapterOvCmp,
  input wire logic        inputOvCmp,
  input wire logic        inputFastOcCmp,
  // Outputs
  input wire logic        extGateDrive,
  input wire logic        chargeEnable,
  input wire logic        conversionEnable,
  input wire logic        intPulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [13:0] penQ;                // Mirror of per-function enables
  logic [15:0] presCnt;             // Cycles of continuous presence
  // Mirror enables from taken writes; raw count runs ahead of sync delay
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      penQ <= `CPS_PEN_RST;
      presCnt <= 16'h0;
    end else begin
      if (write && !waitrequest && address == `CPS_ADDR_PEN) penQ <= writedata[13:0];
      if (!adapterPresent) presCnt <= 16'h0;
      else if (presCnt != 16'hffff) presCnt <= presCnt + 16'h1;
    end
  end
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held past one cycle");
  a_idle_nowait: assert property (!read && !write |-> !waitrequest)
    else $error("waitrequest without request");
  a_inov_trip: assert property (inputOvCmp [*4] ##0 penQ[`CPS_P_INOV] |-> ##[0:2] !chargeEnable)
    else $error("input overvoltage left charge on");
  a_fastoc_trip: assert property (inputFastOcCmp [*4] ##0 penQ[`CPS_P_INOCF] |-> ##[0:2] !chargeEnable)
    else $error("fast overcurrent left charge on");
  a_acov_gateoff: assert property (adapterOvCmp [*4] |-> ##[0:3] !extGateDrive)
    else $error("gate stayed on in adapter overvoltage");
  a_gate_qualify: assert property ($rose(extGateDrive) |-> presCnt >= PRES_CYC)
    else $error("gate on before presence qualified");
  a_pulse_single: assert property (intPulse |=> !intPulse)
    else $error("interrupt pulse longer than one cycle");
  a_conv_write: assert property (write && !waitrequest && address == `CPS_ADDR_CTRL
    |=> conversionEnable == $past(writedata[`CPS_CTRL_CONV]))
    else $error("conversion enable not written");
endmodule
bind cps_supervisor cps_sup_checker #(.PRES_CYC(PRES_CYC)) chk_u (
  .ref_clk(ref_clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .waitrequest(waitrequest), .adapterPresent(adapterPresent),
  .adapterOvCmp(adapterOvCmp), .inputOvCmp(inputOvCmp), .inputFastOcCmp(inputFastOcCmp),
  .extGateDrive(extGateDrive), .chargeEnable(chargeEnable),
  .conversionEnable(conversionEnable), .intPulse(intPulse));
`default_nettype wire

// ---- dv/cps_supervisor_tb.sv ----
// Self-checking bench of the protection supervisor.
// Assumes the partner model and the property checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
`include "cps_regs.vh"
module cps_supervisor_tb;
  localparam int PRES = 10;          // Shortened presence qualification
  logic        ref_clk = 1'b0;       // 200 MHz core clock
  logic        reset_n = 1'b0;       // Async reset, active low
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [15:0] cmp = 16'h0;          // Comparators by protection index, 14 presence
  logic [3:0]  batOc = 4'h0;         // Battery current per scale
  logic [31:0] rd;                   // Last read data
  wire  [31:0] readdata;
  wire         waitrequest, extGateDrive, chargeEnable, conversionEnable, intPulse;
  wire         supplyOk, softStartActive, switching, ucpAboveRise, ucpBelowFall;
  int          err_total = 0;
  int          compares = 0;
  int          pulses = 0;           // Interrupt pulses seen
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (intPulse === 1'b1) pulses <= pulses + 1;
  cps_supervisor #(.PRES_CYC(PRES)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .supplyOk(supplyOk), .adapterPresent(cmp[14]), .adapterOvCmp(cmp[`CPS_P_ACOV]),
    .adapterOvRel(!cmp[`CPS_P_ACOV]), .inputOvCmp(cmp[`CPS_P_INOV]),
    .batteryOvCmp(cmp[`CPS_P_BATOV]), .outputOvCmp(cmp[`CPS_P_OUTOV]),
    .inputOcCmp(cmp[`CPS_P_INOC]), .inputFastOcCmp(cmp[`CPS_P_INOCF]), .batteryOcCmp(batOc),
    .dieOtCmp(cmp[`CPS_P_DIEOT]), .dropoutOvCmp(cmp[`CPS_P_DROV]),
    .capShortCmp(cmp[`CPS_P_CFLY]), .thermOtCmp(cmp[`CPS_P_TSOT]),
    .ratioLowCmp(cmp[`CPS_P_RLOW]), .ratioHighCmp(cmp[`CPS_P_RHIGH]),
    .ucpAboveRise(ucpAboveRise), .ucpBelowFall(ucpBelowFall),
    .softStartActive(softStartActive), .switching(switching), .extGateDrive(extGateDrive),
    .chargeEnable(chargeEnable), .conversionEnable(conversionEnable), .intPulse(intPulse));
  cps_afe_model afe_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .chargeEnable(chargeEnable),
    .noLoad(cmp[`CPS_P_INUC]), .supplyOk(supplyOk), .softStartActive(softStartActive),
    .switching(switching), .ucpAboveRise(ucpAboveRise), .ucpBelowFall(ucpBelowFall));
  // Verdict and end of run
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Bounded wait for charge enable to drop
  task automatic untilLow(input int lim, output int n);
    n = 0;
    while (chargeEnable !== 1'b0 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic waitGate(input logic v, output int n);
    n = 0;
    while (extGateDrive !== v && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      finish_test();
    end
  endtask
  // Host starts charging with both conversion channels on
  task automatic chargeOn();
    bus(1'b1, `CPS_ADDR_CTRL, 32'h1b);
    cyc(30);
    chk("charge started", 32'h1, chargeEnable);
  endtask
  task automatic t_regs();
    bus(1'b0, `CPS_ADDR_PEN, 32'h0);
    chk("enable reset", 32'h3fff, rd);
    bus(1'b0, `CPS_ADDR_UCPTO, 32'h0);
    chk("ucp timeout reset", 32'h1130, rd);
    bus(1'b0, `CPS_ADDR_VDRDG, 32'h0);
    chk("dropout deglitch reset", 32'h640, rd);
    bus(1'b1, 4'h9, 32'hffff);
    bus(1'b0, 4'h9, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("t_regs done");
  endtask
  // Untimed trips, flag read clear and single pulse
  task automatic t_untimed();
    int idx[3];
    int n;
    int p;
    idx = '{`CPS_P_INOV, `CPS_P_INOCF, `CPS_P_INUC};
    foreach (idx[k]) begin
      chargeOn();
      p = pulses;
      @(posedge ref_clk);
      cmp[idx[k]] <= 1'b1;
      untilLow(10, n);
      chk("untimed trip", 32'h1, n < 10);
      cmp[idx[k]] <= 1'b0;
      bus(1'b0, `CPS_ADDR_FLAG, 32'h0);
      chk("flag set", 32'h1, rd[idx[k]]);
      chk("pulse count", 32'h1, pulses - p);
      bus(1'b0, `CPS_ADDR_FLAG, 32'h0);
      chk("flag cleared", 32'h0, rd[idx[k]]);
    end
    $display("t_untimed done");
  endtask
  task automatic t_enbit();
    bus(1'b1, `CPS_ADDR_PEN, 32'h3fff & ~(32'h1 << `CPS_P_INOV));
    chargeOn();
    cmp[`CPS_P_INOV] <= 1'b1;
    cyc(20);
    chk("disabled function", 32'h1, chargeEnable);
    cmp[`CPS_P_INOV] <= 1'b0;
    bus(1'b1, `CPS_ADDR_PEN, 32'h3fff);
    $display("t_enbit done");
  endtask
  // Interrupted condition restarts the 600-cycle deglitch
  task automatic t_deglitch();
    int n;
    chargeOn();
    cmp[`CPS_P_BATOV] <= 1'b1;
    cyc(400);
    cmp[`CPS_P_BATOV] <= 1'b0;
    cyc(3);
    cmp[`CPS_P_BATOV] <= 1'b1;
    cyc(400);
    chk("glitch ignored", 32'h1, chargeEnable);
    untilLow(400, n);
    chk("deglitch span", 32'h1, n >= 198 && n <= 210);
    cmp[`CPS_P_BATOV] <= 1'b0;
    $display("t_deglitch done");
  endtask
  // Scale picks which battery comparator counts
  task automatic t_batoc();
    int n;
    bus(1'b1, `CPS_ADDR_IBATSC, 32'h1);
    chargeOn();
    batOc <= 4'b1101;
    cyc(10100);
    chk("other scale ignored", 32'h1, chargeEnable);
    batOc <= 4'b0010;
    untilLow(10100, n);
    chk("batoc span", 32'h1, n >= 9990 && n <= 10010);
    batOc <= 4'h0;
    $display("t_batoc done");
  endtask
  task automatic t_gate();
    int n;
    cmp[14] <= 1'b1;
    waitGate(1'b1, n);
    chk("presence qualify", 32'h1, n >= PRES && n <= PRES + 6);
    chargeOn();
    cmp[`CPS_P_ACOV] <= 1'b1;
    waitGate(1'b0, n);
    chk("gate off time", 32'h1, n <= 6);
    cyc(2);
    chk("ov clears charge", 32'h0, chargeEnable);
    cmp[`CPS_P_ACOV] <= 1'b0;
    bus(1'b1, `CPS_ADDR_CTRL, 32'h4);
    cyc(20);
    chk("switch disabled", 32'h0, extGateDrive);
    cmp[14] <= 1'b0;
    $display("t_gate done");
  endtask
  task automatic t_therm();
    chargeOn();
    cmp[`CPS_P_TSOT] <= 1'b1;
    cyc(20);
    chk("thermistor unselected", 32'h1, chargeEnable);
    bus(1'b1, `CPS_ADDR_DMCFG, 32'h40);
    cyc(10);
    chk("thermistor trip", 32'h0, chargeEnable);
    cmp[`CPS_P_TSOT] <= 1'b0;
    bus(1'b1, `CPS_ADDR_DMCFG, 32'h0);
    $display("t_therm done");
  endtask
  // Ratio errors block a start but not a running charge
  task automatic t_ratio();
    for (int i = `CPS_P_RLOW; i <= `CPS_P_RHIGH; i++) begin
      cmp[i] <= 1'b1;
      bus(1'b1, `CPS_ADDR_CTRL, 32'h1b);
      cyc(5);
      chk("ratio blocks start", 32'h0, chargeEnable);
      cmp[i] <= 1'b0;
      chargeOn();
      cmp[i] <= 1'b1;
      cyc(20);
      chk("ratio off when running", 32'h1, chargeEnable);
      cmp[i] <= 1'b0;
      bus(1'b1, `CPS_ADDR_CTRL, 32'h0);
    end
    $display("t_ratio done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_untimed();
    t_enbit();
    t_deglitch();
    t_batoc();
    t_therm();
    t_ratio();
    t_gate();
    finish_test();
  end
endmodule
`default_nettype wire

// ---- src/cps_regs.vh ----
// Register map, field positions and timing constants of the protection supervisor.
// Assumes a 200 MHz core clock and a 32-bit Avalon-MM slave with word addresses.
`ifndef CPS_REGS_VH
`define CPS_REGS_VH

// Word addresses (byte address / 4)
`define CPS_ADDR_CTRL     4'h0
`define CPS_ADDR_PEN      4'h1
`define CPS_ADDR_FLAG     4'h2
`define CPS_ADDR_STAT     4'h3
`define CPS_ADDR_IBATSC   4'h4
`define CPS_ADDR_THRESH   4'h5
`define CPS_ADDR_DMCFG    4'h6
`define CPS_ADDR_UCPTO    4'h7
`define CPS_ADDR_VDRDG    4'h8

// Control register fields
`define CPS_CTRL_CHG      0
`define CPS_CTRL_CONV     1
`define CPS_CTRL_SWDIS    2
`define CPS_CTRL_VBUSCONV 3
`define CPS_CTRL_VOUTCONV 4

// Minus-line config fields (thermistor select sits at bit 6)
`define CPS_DM_DIS        0
`define CPS_DM_TSSEL      6

// Protection indices, 14 functions
`define CPS_P_ACOV        0
`define CPS_P_INOV        1
`define CPS_P_BATOV       2
`define CPS_P_OUTOV       3
`define CPS_P_INOC        4
`define CPS_P_INOCF       5
`define CPS_P_INUC        6
`define CPS_P_BATOC       7
`define CPS_P_DIEOT       8
`define CPS_P_DROV        9
`define CPS_P_CFLY        10
`define CPS_P_TSOT        11
`define CPS_P_RLOW        12
`define CPS_P_RHIGH       13
`define CPS_NPROT         14

// Reset values
`define CPS_PEN_RST       14'h3fff
`define CPS_IBATSC_RST    2'h0
`define CPS_UCPTO_RST     16'h1130
`define CPS_VDRDG_RST     16'h0640

// Timing figures in ns and cycle counts at 5 ns
`define CPS_CLK_NS        5
`define CPS_T3US_NS       3000
`define CPS_T50US_NS      50000
`define CPS_T3US_CYC      (`CPS_T3US_NS / `CPS_CLK_NS)
`define CPS_T50US_CYC     (`CPS_T50US_NS / `CPS_CLK_NS)

`endif

// ---- src/cps_supervisor.v ----
// Charger protection supervisor: fourteen protection functions over comparator
// inputs from the analog front end, with an Avalon-MM register slave.
// Assumes comparator inputs are asynchronous to ref_clk and are synchronised here.
//
// How it works
// - Fourteen protections, most gated by enables
// - Per-function enable bit disables only that
// - Adapter OV trips gate off, clears charge
// - Gate on only after presence qualified
// - Gate off after REACT_CYC reaction cycles; OFF_CYC is not used
// - Input OV above undervoltage, no deglitch
// - Battery OV after 3us deglitch
// - Output OV fixed level, 3us deglitch
// - Input OC after 50us, charge only
// - Fast input OC, no deglitch
// - Battery OC after 50us, charge only
// - Battery current scale is register selectable
// - Undercurrent arms rise level, starts timer
// - Timeout arms fall level; below fall trips
// - Die overtemp after 3us deglitch
// - Flying cap short aborts soft start
// - Dropout OV after programmable deglitch
// - Thermistor OT needs select and line on
// - Ratio out of window blocks charge start
// - Ratio checks off after charging starts
// - Event sets flag, read clears, one pulse
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cps_regs.vh"

module cps_supervisor #(
  parameter PRES_CYC  = 20000,              // Presence qualification cycles
  parameter REACT_CYC = 1,                  // Adapter OV reaction cycles
  parameter OFF_CYC   = 1                   // Adapter OV turn-off cycles
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // Avalon-MM slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output wire [31:0] readdata,
  output wire        waitrequest,
  // Comparator inputs from analog front end
  input  wire        supplyOk,              // Supply above undervoltage
  input  wire        adapterPresent,        // Adapter above presence level
  input  wire        adapterOvCmp,          // Adapter at or above trip
  input  wire        adapterOvRel,          // Adapter below trip minus hysteresis
  input  wire        inputOvCmp,
  input  wire        batteryOvCmp,
  input  wire        outputOvCmp,
  input  wire        inputOcCmp,
  input  wire        inputFastOcCmp,
  input  wire [3:0]  batteryOcCmp,          // One comparator per scale setting
  input  wire        dieOtCmp,
  input  wire        dropoutOvCmp,
  input  wire        capShortCmp,           // Phase resistance at or below limit
  input  wire        thermOtCmp,
  input  wire        ratioLowCmp,
  input  wire        ratioHighCmp,
  input  wire        ucpAboveRise,          // Input current above rise level
  input  wire        ucpBelowFall,          // Input current below fall level
  input  wire        softStartActive,       // Converter in soft start
  input  wire        switching,             // Converter has started switching
  // Outputs
  output reg         extGateDrive,
  output wire        chargeEnable,
  output wire        conversionEnable,
  output reg         intPulse
);

  // Synchroniser stages for all asynchronous comparator inputs
  localparam NS = 23;
  wire [NS-1:0] rawIn = {switching, softStartActive, ucpBelowFall, ucpAboveRise,
                         ratioHighCmp, ratioLowCmp, thermOtCmp, capShortCmp,
                         dropoutOvCmp, dieOtCmp, batteryOcCmp, inputFastOcCmp,
                         inputOcCmp, outputOvCmp, batteryOvCmp, inputOvCmp,
                         adapterOvRel, adapterOvCmp, adapterPresent, supplyOk};
  reg  [NS-1:0] syncA_q;                    // First stage, read only by second
  reg  [NS-1:0] sync_q;                     // Second stage, safe to use

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= {NS{1'b0}};
      sync_q  <= {NS{1'b0}};
    end else begin
      syncA_q <= rawIn;
      sync_q  <= syncA_q;
    end
  end

  // Named views of synchronised inputs
  wire sOk    = sync_q[0];
  wire sPres  = sync_q[1];
  wire sAcOv  = sync_q[2];
  wire sAcRel = sync_q[3];
  wire sInOv  = sync_q[4];
  wire sBatOv = sync_q[5];
  wire sOutOv = sync_q[6];
  wire sInOc  = sync_q[7];
  wire sInOcF = sync_q[8];
  wire [3:0] sBatOc = sync_q[12:9];
  wire sDieOt = sync_q[13];
  wire sDrOv  = sync_q[14];
  wire sCap   = sync_q[15];
  wire sTsOt  = sync_q[16];
  wire sRLow  = sync_q[17];
  wire sRHigh = sync_q[18];
  wire sUcpR  = sync_q[19];
  wire sUcpF  = sync_q[20];
  wire sSoft  = sync_q[21];
  wire sSw    = sync_q[22];

  // Software registers
  reg  [4:0]  ctrl_q;                       // Enables, switch disable, conversions
  reg  [13:0] pen_q;                        // Per-protection enables
  reg  [13:0] flag_q;                       // Sticky event flags
  reg  [1:0]  ibatSc_q;                     // Battery current scale select
  reg  [6:0]  dmCfg_q;                      // Minus-line config
  reg  [15:0] ucpTo_q;                      // Undercurrent arm timeout, cycles
  reg  [15:0] vdrDg_q;                      // Dropout deglitch, cycles
  reg  [31:0] rdata_q;                      // Registered read data
  reg         ack_q;                        // One wait state then ack

  wire chgEn  = ctrl_q[`CPS_CTRL_CHG];
  wire convEn = ctrl_q[`CPS_CTRL_CONV];
  wire anyEn  = chgEn | convEn;
  assign chargeEnable     = chgEn;
  assign conversionEnable = convEn;

  // Deglitch counters restart when the condition drops
  localparam CW = 16;
  function [CW-1:0] dgNext;
    input          cond;
    input [CW-1:0] cnt;
    input [CW-1:0] lim;
    begin
      if (!cond)
        dgNext = {CW{1'b0}};
      else if (cnt < lim)
        dgNext = cnt + 1'b1;
      else
        dgNext = cnt;
    end
  endfunction

  // Raw trip conditions, each gated by its own enable and condition
  reg  [13:0] cond;
  wire        batOcSel = sBatOc[ibatSc_q];
  reg         ucpArmed_q;                   // Fall level armed
  reg         ucpRun_q;                     // Arm timer running
  reg  [15:0] ucpCnt_q;
  reg         started_q;                    // Charging successfully started
  wire        ratioOn  = (chgEn | convEn) & ~started_q;
  wire        ratioCh  = ctrl_q[`CPS_CTRL_VBUSCONV] & ctrl_q[`CPS_CTRL_VOUTCONV];

  always @* begin
    cond                  = 14'h0000;
    cond[`CPS_P_ACOV]     = sPres & ~ctrl_q[`CPS_CTRL_SWDIS] & sAcOv;
    cond[`CPS_P_INOV]     = sOk & sInOv;
    cond[`CPS_P_BATOV]    = anyEn & sBatOv;
    cond[`CPS_P_OUTOV]    = anyEn & sOutOv;
    cond[`CPS_P_INOC]     = chgEn & sInOc;
    cond[`CPS_P_INOCF]    = chgEn & sInOcF;
    cond[`CPS_P_INUC]     = chgEn & ucpArmed_q & sUcpF;
    cond[`CPS_P_BATOC]    = chgEn & batOcSel;
    cond[`CPS_P_DIEOT]    = anyEn & sDieOt;
    cond[`CPS_P_DROV]     = chgEn & sDrOv;
    cond[`CPS_P_CFLY]     = chgEn & sSoft & ~started_q & sCap;
    cond[`CPS_P_TSOT]     = anyEn & ~dmCfg_q[`CPS_DM_DIS]
                            & dmCfg_q[`CPS_DM_TSSEL] & sTsOt;
    cond[`CPS_P_RLOW]     = ratioOn & ratioCh & sRLow;
    cond[`CPS_P_RHIGH]    = ratioOn & ratioCh & sRHigh;
    cond                  = cond & pen_q;
  end

  // Deglitch counters for the timed functions
  reg [CW-1:0] dBat_q, dOut_q, dInOc_q, dBatOc_q, dDie_q, dDr_q;
  localparam integer  L3I   = `CPS_T3US_CYC;   // Cycle counts, cut to counter width
  localparam integer  L50I  = `CPS_T50US_CYC;
  localparam [CW-1:0] L3US  = L3I[CW-1:0];
  localparam [CW-1:0] L50US = L50I[CW-1:0];

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dBat_q   <= {CW{1'b0}};
      dOut_q   <= {CW{1'b0}};
      dInOc_q  <= {CW{1'b0}};
      dBatOc_q <= {CW{1'b0}};
      dDie_q   <= {CW{1'b0}};
      dDr_q    <= {CW{1'b0}};
    end else begin
      dBat_q   <= dgNext(cond[`CPS_P_BATOV], dBat_q, L3US);
      dOut_q   <= dgNext(cond[`CPS_P_OUTOV], dOut_q, L3US);
      dInOc_q  <= dgNext(cond[`CPS_P_INOC], dInOc_q, L50US);
      dBatOc_q <= dgNext(cond[`CPS_P_BATOC], dBatOc_q, L50US);
      dDie_q   <= dgNext(cond[`CPS_P_DIEOT], dDie_q, L3US);
      dDr_q    <= dgNext(cond[`CPS_P_DROV], dDr_q, vdrDg_q);
    end
  end

  // Qualified trips; untimed functions act at once
  wire [13:0] trip;
  assign trip[`CPS_P_ACOV]  = cond[`CPS_P_ACOV];
  assign trip[`CPS_P_INOV]  = cond[`CPS_P_INOV];
  assign trip[`CPS_P_BATOV] = cond[`CPS_P_BATOV] & (dBat_q >= L3US);
  assign trip[`CPS_P_OUTOV] = cond[`CPS_P_OUTOV] & (dOut_q >= L3US);
  assign trip[`CPS_P_INOC]  = cond[`CPS_P_INOC] & (dInOc_q >= L50US);
  assign trip[`CPS_P_INOCF] = cond[`CPS_P_INOCF];
  assign trip[`CPS_P_INUC]  = cond[`CPS_P_INUC];
  assign trip[`CPS_P_BATOC] = cond[`CPS_P_BATOC] & (dBatOc_q >= L50US);
  assign trip[`CPS_P_DIEOT] = cond[`CPS_P_DIEOT] & (dDie_q >= L3US);
  assign trip[`CPS_P_DROV]  = cond[`CPS_P_DROV] & (dDr_q >= vdrDg_q);
  assign trip[13:10]        = cond[13:10];

  // Undercurrent arming: rise level and timer first, then fall level
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ucpArmed_q <= 1'b0;
      ucpRun_q   <= 1'b0;
      ucpCnt_q   <= 16'h0000;
    end else if (!chgEn) begin
      ucpArmed_q <= 1'b0;                   // Rearm on next charge start
      ucpRun_q   <= 1'b1;
      ucpCnt_q   <= 16'h0000;
    end else if (ucpRun_q) begin
      if (sUcpR) begin
        ucpRun_q   <= 1'b0;
        ucpArmed_q <= 1'b1;
      end else if (ucpCnt_q >= ucpTo_q) begin
        ucpRun_q   <= 1'b0;
        ucpArmed_q <= 1'b1;
      end else begin
        ucpCnt_q <= ucpCnt_q + 16'h0001;
      end
    end
  end

  // Start tracking: ratio and cap checks end once switching runs with soft start over
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      started_q <= 1'b0;
    else if (!chgEn)
      started_q <= 1'b0;
    else if (sSw & ~sSoft)
      started_q <= 1'b1;
  end

  // Gate state machine, one-hot
  localparam [3:0] G_OFF = 4'h1, G_QUAL = 4'h2, G_ON = 4'h4, G_TRIP = 4'h8;
  reg [3:0]  gst_q;
  reg [15:0] gcnt_q;
  reg        acLatched_q;                   // Adapter OV held until hysteresis

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gst_q        <= G_OFF;
      gcnt_q       <= 16'h0000;
      extGateDrive <= 1'b0;
      acLatched_q  <= 1'b0;
    end else begin
      if (trip[`CPS_P_ACOV])
        acLatched_q <= 1'b1;
      else if (sAcRel)
        acLatched_q <= 1'b0;
      case (gst_q)
        G_OFF: begin
          extGateDrive <= 1'b0;
          gcnt_q       <= 16'h0000;
          if (sPres & ~ctrl_q[`CPS_CTRL_SWDIS] & ~acLatched_q)
            gst_q <= G_QUAL;
        end
        G_QUAL: begin
          if (!sPres || ctrl_q[`CPS_CTRL_SWDIS] || acLatched_q) begin
            gst_q <= G_OFF;
          end else if (gcnt_q >= PRES_CYC[15:0] - 16'h0001) begin
            gst_q        <= G_ON;
            extGateDrive <= 1'b1;
          end else begin
            gcnt_q <= gcnt_q + 16'h0001;
          end
        end
        G_ON: begin
          gcnt_q <= 16'h0000;
          if (trip[`CPS_P_ACOV])
            gst_q <= G_TRIP;
          else if (!sPres || ctrl_q[`CPS_CTRL_SWDIS]) begin
            gst_q        <= G_OFF;
            extGateDrive <= 1'b0;
          end
        end
        G_TRIP: begin
          if (gcnt_q >= REACT_CYC[15:0] - 16'h0001) begin
            extGateDrive <= 1'b0;
            gst_q        <= G_OFF;
          end else begin
            gcnt_q <= gcnt_q + 16'h0001;
          end
        end
        default: begin
          gst_q        <= G_OFF;
          extGateDrive <= 1'b0;
        end
      endcase
    end
  end

  // Avalon slave: one wait state, read data registered
  wire acc     = (read | write) & ~ack_q;
  wire wrTake  = write & ack_q;
  wire rdTake  = read & ack_q;
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata    = rdata_q;

  function [31:0] rdMux;
    input [3:0] a;
    begin
      case (a)
        `CPS_ADDR_CTRL:   rdMux = {27'h0, ctrl_q};
        `CPS_ADDR_PEN:    rdMux = {18'h0, pen_q};
        `CPS_ADDR_FLAG:   rdMux = {18'h0, flag_q};
        `CPS_ADDR_STAT:   rdMux = {26'h0, started_q, ucpArmed_q, gst_q == G_TRIP,
                                   acLatched_q, extGateDrive, sOk};
        `CPS_ADDR_IBATSC: rdMux = {30'h0, ibatSc_q};
        `CPS_ADDR_DMCFG:  rdMux = {25'h0, dmCfg_q};
        `CPS_ADDR_UCPTO:  rdMux = {16'h0, ucpTo_q};
        `CPS_ADDR_VDRDG:  rdMux = {16'h0, vdrDg_q};
        default:          rdMux = 32'h0000_0000;
      endcase
    end
  endfunction

  // Register writes, flags and charge-enable clearing
  wire anyTrip = |trip;
  wire flagRd  = rdTake & (address == `CPS_ADDR_FLAG);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q   <= 5'h00;
      pen_q    <= `CPS_PEN_RST;
      flag_q   <= 14'h0000;
      ibatSc_q <= `CPS_IBATSC_RST;
      dmCfg_q  <= 7'h00;
      ucpTo_q  <= `CPS_UCPTO_RST;
      vdrDg_q  <= `CPS_VDRDG_RST;
      rdata_q  <= 32'h0000_0000;
      ack_q    <= 1'b0;
      intPulse <= 1'b0;
    end else begin
      ack_q <= acc;
      if (acc && read)
        rdata_q <= rdMux(address);
      if (wrTake) begin
        case (address)
          `CPS_ADDR_CTRL:   ctrl_q   <= writedata[4:0];
          `CPS_ADDR_PEN:    pen_q    <= writedata[13:0];
          `CPS_ADDR_IBATSC: ibatSc_q <= writedata[1:0];
          `CPS_ADDR_DMCFG:  dmCfg_q  <= writedata[6:0];
          `CPS_ADDR_UCPTO:  ucpTo_q  <= writedata[15:0];
          `CPS_ADDR_VDRDG:  vdrDg_q  <= writedata[15:0];
          default: ;
        endcase
      end
      // A trip wins over a software write of charge enable
      if (anyTrip)
        ctrl_q[`CPS_CTRL_CHG] <= 1'b0;
      // Read clears only bits returned; a later event is kept
      flag_q   <= (flagRd ? flag_q & ~rdata_q[13:0] : flag_q) | trip;
      intPulse <= |(trip & ~flag_q);
    end
  end

endmodule
`default_nettype wire
